// [core/sar_ctl_pkg.sv]
// package: constants for the successive-approximation converter control
package sar_ctl_pkg;
    localparam int          DATA_W           = 8;
    localparam int          CONV_CLOCKS      = 40;
    localparam int          CNT_W            = 6;
    localparam logic [5:0]  CNT_ZERO         = 6'h00;
    localparam logic [5:0]  CNT_ONE          = 6'h01;
    localparam logic [5:0]  CNT_LAST         = 6'h28;
    localparam logic [5:0]  SETTLE_PER_BIT   = 6'h05;
    localparam logic [2:0]  GUARD_CLOCKS     = 3'h4;
    localparam logic [2:0]  GUARD_ZERO       = 3'h0;
    localparam logic [2:0]  GUARD_ONE        = 3'h1;
    localparam logic [7:0]  MSB_MASK         = 8'h80;
    localparam logic [7:0]  ZERO_CODE        = 8'h00;
    localparam logic [7:0]  LATCH_RESET      = 8'hff;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_GUARD
    } conv_state_t;
endpackage : sar_ctl_pkg

// [core/sar_search_step.sv]
// module: one binary-search step of the approximation register
`timescale 1ns/1ps
module sar_search_step
    import sar_ctl_pkg::*;
#(
    parameter int WIDTH = DATA_W
)(
    // current trial and bit under test
    input  wire logic [WIDTH-1:0] i_trial,
    input  wire logic [WIDTH-1:0] i_bit_mask,
    // comparator: analog input above trial tap
    input  wire logic             i_above,
    // next trial and next bit mask
    output logic      [WIDTH-1:0] o_trial,
    output logic      [WIDTH-1:0] o_bit_mask
);
    // ------------------------------------------------------------
    // keep the bit if the input is above the tap, then try the next
    // ------------------------------------------------------------
    always_comb
    begin
        o_bit_mask = i_bit_mask >> 1;
        o_trial    = i_above ? (i_trial | o_bit_mask) : ((i_trial & ~i_bit_mask) | o_bit_mask);
    end
endmodule : sar_search_step

// [core/sar_conv_ctl.sv]
// module: control logic of an 8-bit successive-approximation converter
//
// Behaviour
// - the result is found by binary search over 256 taps, midpoint first, then 3/4 if above.
// - each conversion lasts exactly forty clock periods from start to completion.
// - the output code is complementary binary, full scale gives all zeros.
// - at completion the selected tap code is latched and the done flag rises.
// - the output latch holds the old result during a new conversion until it completes.
// - data outputs are driven while output enable is high and released while it is low.
// - feeding the done flag back to start gives free-running conversion once a first conversion has raised done; reset leaves done low.
// - a start during a conversion clears the approximation register and restarts it.
// - the done flag is low at least forty clock periods per conversion and then goes high.
// - transfer of the new result to the output latch begins as the done flag rises.
`timescale 1ns/1ps
module sar_conv_ctl
    import sar_ctl_pkg::*;
#(
    parameter int WIDTH = DATA_W
)(
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    // conversion control
    input  wire logic             i_start,
    input  wire logic             i_output_enable,
    // comparator: analog_input_level above the trial tap
    input  wire logic             i_input_above_tap,
    // trial tap code to the ladder switches
    output logic      [WIDTH-1:0] o_ladder_tap,
    // conversion status
    output logic                  o_conversion_done,
    // three-state data bus
    output logic      [WIDTH-1:0] o_data,
    output logic      [WIDTH-1:0] o_data_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    conv_state_t      state_q, state_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic [2:0]       guard_q, guard_d;
    logic [WIDTH-1:0] approximation_register_q, approximation_register_d;
    logic [WIDTH-1:0] bit_mask_q, bit_mask_d;
    logic [WIDTH-1:0] latch_q, latch_d;
    logic             done_q, done_d;
    logic [WIDTH-1:0] step_trial;
    logic [WIDTH-1:0] step_mask;
    logic             step_now;
    logic             start_ok;

    sar_search_step #(.WIDTH(WIDTH)) u_step (
        .i_trial    (approximation_register_q),
        .i_bit_mask (bit_mask_q),
        .i_above    (i_input_above_tap),
        .o_trial    (step_trial),
        .o_bit_mask (step_mask)
    );

    // one search step every few clocks lets the ladder settle; 8 steps fit in 40
    assign step_now = (count_q != CNT_ZERO) && (count_q <= (SETTLE_PER_BIT * 6'(WIDTH)))
                      && ((count_q % SETTLE_PER_BIT) == CNT_ZERO);
    // starts within the guard gap after done are ignored
    assign start_ok = i_start && !(state_q == ST_GUARD && guard_q != GUARD_ZERO);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_d                  = state_q;
        count_d                  = count_q;
        guard_d                  = guard_q;
        approximation_register_d = approximation_register_q;
        bit_mask_d               = bit_mask_q;
        latch_d                  = latch_q;
        done_d                   = done_q;
        case (state_q)
            ST_CONVERT:
            begin
                if (start_ok)
                begin
                    // restart: clear and begin again from the midpoint
                    approximation_register_d = MSB_MASK;
                    bit_mask_d               = MSB_MASK;
                    count_d                  = CNT_ONE;
                end
                else if (count_q == CNT_LAST)
                begin
                    // eighth step decides the last bit on the same edge the latch loads
                    approximation_register_d = step_trial;
                    bit_mask_d               = step_mask;
                    // latch inverted code; old value held until now
                    latch_d = ~step_trial;
                    done_d  = 1'b1;
                    guard_d = GUARD_CLOCKS - GUARD_ONE;
                    state_d = ST_GUARD;
                end
                else
                begin
                    count_d = count_q + CNT_ONE;
                    if (step_now)
                    begin
                        // midpoint first, then 3/4 or 1/4, one bit per step
                        approximation_register_d = step_trial;
                        bit_mask_d               = step_mask;
                    end
                end
            end
            ST_GUARD:
            begin
                if (guard_q != GUARD_ZERO)
                begin
                    guard_d = guard_q - GUARD_ONE;
                end
                else if (start_ok)
                begin
                    done_d                   = 1'b0;
                    approximation_register_d = MSB_MASK;
                    bit_mask_d               = MSB_MASK;
                    count_d                  = CNT_ONE;
                    state_d                  = ST_CONVERT;
                end
            end
            default:
            begin
                // idle holds the result and done until a start is taken
                if (start_ok)
                begin
                    done_d                   = 1'b0;
                    approximation_register_d = MSB_MASK;
                    bit_mask_d               = MSB_MASK;
                    count_d                  = CNT_ONE;
                    state_d                  = ST_CONVERT;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            state_q                  <= ST_IDLE;
            count_q                  <= CNT_ZERO;
            guard_q                  <= GUARD_ZERO;
            approximation_register_q <= ZERO_CODE;
            bit_mask_q               <= ZERO_CODE;
            latch_q                  <= LATCH_RESET;
            done_q                   <= 1'b0;
        end
        else
        begin
            state_q                  <= state_d;
            count_q                  <= count_d;
            guard_q                  <= guard_d;
            approximation_register_q <= approximation_register_d;
            bit_mask_q               <= bit_mask_d;
            latch_q                  <= latch_d;
            done_q                   <= done_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_ladder_tap      = approximation_register_q;
    assign o_conversion_done = done_q;
    assign o_data            = latch_q;
    assign o_data_oe         = {WIDTH{i_output_enable}};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // clocks since the last accepted start, kept apart from count_q so timing is checked
    logic [CNT_W-1:0] age_q, age_d;

    always_comb
    begin
        age_d = age_q;
        if (start_ok)
        begin
            age_d = CNT_ZERO;
        end
        else if (age_q != '1)
        begin
            age_d = age_q + CNT_ONE;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_reset)
        begin
            age_q <= CNT_ZERO;
        end
        else
        begin
            age_q <= age_d;
        end
    end

    conv_length_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(done_q) |-> age_q == CNT_W'(CONV_CLOCKS))
        else $error("conversion length check");

    done_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_q == ST_CONVERT && count_q == CNT_LAST && !start_ok) |=> done_q)
        else $error("done did not rise at end of conversion");

    latch_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_q == ST_CONVERT && !(count_q == CNT_LAST && !start_ok)) |=> $stable(latch_q))
        else $error("latch changed during conversion");

    latch_invert_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(done_q) |-> latch_q == ~approximation_register_q)
        else $error("latched code not complemented");

    restart_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_q == ST_CONVERT && start_ok) |=> approximation_register_q == MSB_MASK && !done_q)
        else $error("restart did not clear register");

    guard_ignore_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(done_q) |-> done_q[*4])
        else $error("start accepted inside guard gap");

    oe_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_data_oe == {WIDTH{i_output_enable}})
        else $error("output enable not followed");

    done_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_q == ST_CONVERT) |-> age_q < CNT_W'(CONV_CLOCKS))
        else $error("busy period too long");

    midpoint_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(state_q == ST_CONVERT) |-> approximation_register_q == MSB_MASK)
        else $error("search does not start at midpoint");

    hold_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_q != ST_CONVERT && !start_ok) |=> $stable(latch_q))
        else $error("result not held after conversion");
endmodule : sar_conv_ctl

// [sim/sar_host_model.sv]
// host-side partner: ladder comparator and start source
`timescale 1ns/1ps
module sar_host_model
    import sar_ctl_pkg::*;
(
    // ladder and comparator
    input  wire logic [DATA_W-1:0] i_ladder_tap,
    input  wire logic [DATA_W-1:0] i_input_level,
    output logic                   o_above,
    // start source
    input  wire logic              i_free_run,
    input  wire logic              i_host_start,
    input  wire logic              i_done,
    output logic                   o_start
);
    // at-or-above keeps the trial bit, so the search lands on the level itself
    assign o_above = (i_input_level >= i_ladder_tap);
    // done fed back gives free-running; bench pulses cover power-up
    assign o_start = i_free_run ? i_done : i_host_start;
endmodule : sar_host_model

// [sim/test_sar_conv_ctl.sv]
// testbench: conversion timing, result code, restart, guard and bus enable
`timescale 1ns/1ps
module test_sar_conv_ctl
    import sar_ctl_pkg::*;
;
    logic              i_ref_clk, i_reset, host_start, oe, free_run, above, start, done;
    logic [DATA_W-1:0] level, tap, data, data_oe;
    int                bad_count, checked, cycles, n;

    sar_conv_ctl dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_start(start),
        .i_output_enable(oe), .i_input_above_tap(above), .o_ladder_tap(tap),
        .o_conversion_done(done), .o_data(data), .o_data_oe(data_oe));
    sar_host_model host_u (.i_ladder_tap(tap), .i_input_level(level), .o_above(above),
        .i_free_run(free_run), .i_host_start(host_start), .i_done(done), .o_start(start));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic tick;
        @(posedge i_ref_clk);
        #2;
    endtask : tick

    task automatic expect8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : expect8

    // one-clock start pulse, well inside the allowed width
    task automatic pulse;
        host_start = 1'b1;
        tick();
        host_start = 1'b0;
    endtask : pulse

    // optional early start, then a start that must run forty clocks to done
    task automatic run(input logic [7:0] lvl, input int gap);
        logic [7:0] old;
        old = data;
        level = lvl;
        if (gap > 0)
        begin
            pulse();
            repeat (gap) tick();
        end
        pulse();
        tick();
        n = 1;
        expect8({7'h00, done}, 8'h00, "busy after start");
        expect8(tap, MSB_MASK, "midpoint first");
        while (done !== 1'b1 && n < 60)
        begin
            expect8(data, old, "latch held");
            if (n == 6)
                expect8(tap, {lvl[7], 1'b1, 6'h00}, "second trial");
            tick();
            n++;
        end
        expect8(8'(n), 8'(CONV_CLOCKS), "conversion length");
        expect8(data, ~lvl, "result code");
    endtask : run

    task automatic t_levels;
        logic [7:0] lv [4] = '{8'hff, 8'h00, 8'ha5, 8'h80};
        foreach (lv[i])
        begin
            run(lv[i], 0);
            repeat (4) tick(); // host waits out the guard
        end
        $display("test levels done");
    endtask : t_levels

    task automatic t_restart;
        run(8'h3c, 10);
        repeat (4) tick();
        $display("test restart done");
    endtask : t_restart

    task automatic t_guard;
        run(8'h5a, 0);
        pulse();
        repeat (5)
        begin
            expect8({7'h00, done}, 8'h01, "start in guard ignored");
            expect8(data, 8'ha5, "result kept");
            tick();
        end
        $display("test guard done");
    endtask : t_guard

    task automatic t_enable;
        oe = 1'b0;
        tick();
        expect8(data_oe, 8'h00, "bus released");
        oe = 1'b1;
        tick();
        expect8(data_oe, 8'hff, "bus driven");
        $display("test enable done");
    endtask : t_enable

    task automatic t_free;
        level = 8'h11;
        free_run = 1'b1;
        n = 0;
        while (done !== 1'b0 && n < 60)
        begin
            tick();
            n++;
        end
        while (done !== 1'b1 && n < 60)
        begin
            tick();
            n++;
        end
        // rise to rise: forty clocks of conversion plus the guard gap
        n = 0;
        while (done !== 1'b0 && n < 60)
        begin
            tick();
            n++;
        end
        while (done !== 1'b1 && n < 60)
        begin
            tick();
            n++;
        end
        expect8(8'(n), 8'(CONV_CLOCKS + int'(GUARD_CLOCKS)), "free-running period");
        expect8(data, 8'hee, "free-running result");
        free_run = 1'b0;
        repeat (4) tick();
        $display("test free done");
    endtask : t_free

    task automatic conclude;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // a hang counts against the run and still reaches the report
    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t timeout", $time);
            conclude();
        end
    end

    initial
    begin
        {bad_count, checked, cycles, n} = '0;
        {i_reset, host_start, oe, free_run, level} = {4'b1010, 8'h00};
        repeat (8) @(posedge i_ref_clk);
        #2;
        i_reset = 1'b0;
        t_levels();
        t_restart();
        t_guard();
        t_enable();
        t_free();
        conclude();
    end
endmodule : test_sar_conv_ctl
